// file: design/pci_internal_bus_arbiter.sv
// internal pci bus arbiter with its configuration register
`timescale 1ns/100ps
`default_nettype none
`include "pci_arb_defs.svh"

module pci_internal_bus_arbiter
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire logic bridge_req,
	output logic bridge_gnt,
	input wire logic [2:0] pci_req_l,
	output logic [2:0] pci_gnt_l,
	input wire logic pci_frame_l,
	input wire logic pci_irdy_l,
	output logic ext_arb_req_l,
	input wire logic ext_arb_gnt_l,
	output logic [3:0] broken_mask
);

	// ==========================================================
	// pin synchronisers, all idle high
	logic [5:0] pin_meta_r;
	logic [5:0] pin_sync_r;
	logic frame_d_r;

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pin_meta_r <= 6'h3f;
			pin_sync_r <= 6'h3f;
			frame_d_r <= 1'b1;
		end
		else
		begin
			pin_meta_r <= {ext_arb_gnt_l, pci_irdy_l, pci_frame_l, pci_req_l};
			pin_sync_r <= pin_meta_r;
			frame_d_r <= pin_sync_r[3];
		end
	end

	wire [3:0] req_all = {~pin_sync_r[2:0], bridge_req};
	wire frame_s = pin_sync_r[3];
	wire bus_idle = pin_sync_r[3] & pin_sync_r[4];
	wire ext_gnt_s = ~pin_sync_r[5];
	wire frame_fall = frame_d_r & ~frame_s;

	// ==========================================================
	// configuration register at 48h
	logic [31:0] arb_reg_r;
	wire [31:0] be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
	wire reg_hit = cfg_addr == `ARB_REG_OFFSET;
	wire [31:0] wr_mask = be_mask & `ARB_REG_WMASK;
	wire [31:0] arb_reg_nxt = (arb_reg_r & ~wr_mask) | (cfg_wdata & wr_mask);

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			arb_reg_r <= `ARB_REG_RESET;
			cfg_rdata <= 32'h00000000;
			cfg_rvalid <= 1'b0;
		end
		else
		begin
			if (cfg_wr && reg_hit)
				arb_reg_r <= arb_reg_nxt;
			cfg_rvalid <= cfg_rd;
			if (cfg_rd)
				cfg_rdata <= reg_hit ? arb_reg_r : 32'h00000000;
		end
	end

	wire [3:0] enables = arb_reg_r[`ARB_EN_MSB:`ARB_EN_LSB];
	wire ext_mode = arb_reg_r[`ARB_EXT_BIT];
	wire bm_en = arb_reg_r[`ARB_BM_EN_BIT];
	wire refresh_en = arb_reg_r[`ARB_REFRESH_BIT];
	wire [7:0] fair_init = arb_reg_r[`ARB_FAIR_MSB:`ARB_FAIR_LSB];
	wire toggle_en = arb_reg_r[`ARB_TOGGLE_BIT];

	// ==========================================================
	// arbitration state
	pci_arb_pkg::arb_state_t state_r;
	pci_arb_pkg::arb_state_t state_nxt;
	pci_arb_pkg::req_idx_t owner_r;
	logic [3:0] broken_r;
	logic [3:0] served_r;
	logic [4:0] bm_cnt_r;
	logic [7:0] fair_cnt_r;
	logic armed_r;
	logic [1:0] tog_cnt_r;

	arb_pick_if pick_bus();

	arb_rr_pick u_pick
	(
		.pk(pick_bus.picker)
	);

	// broken masters stay out of the pool until refreshed or reset
	assign pick_bus.eligible = req_all & enables & ~broken_r & {4{~ext_mode}};
	assign pick_bus.last = owner_r;

	wire [3:0] owner_hot = 4'h1 << owner_r;
	wire owner_req = |(req_all & owner_hot);
	wire owner_en = |(enables & owner_hot);
	wire other_req = |(pick_bus.eligible & ~owner_hot);
	wire granted = state_r != pci_arb_pkg::ST_IDLE;
	wire new_grant = (state_r == pci_arb_pkg::ST_IDLE) && pick_bus.valid;

	// ==========================================================
	// broken master watchdog
	wire bm_count = bm_en && (state_r == pci_arb_pkg::ST_WAIT) && bus_idle && frame_s;
	wire bm_timeout = bm_count && (bm_cnt_r == (`ARB_BM_CYCLES - `ARB_BM_ONE));

	// ==========================================================
	// fairness counter: a zero field never preempts
	wire fair_dec = armed_r && other_req && (fair_cnt_r != `ARB_FAIR_ZERO);
	wire fair_zero = fair_init == `ARB_FAIR_ZERO;
	wire preempt = !fair_zero && armed_r && other_req && (fair_cnt_r == `ARB_FAIR_ZERO);

	wire release_gnt = !owner_req || !owner_en || ext_mode || bm_timeout || preempt;

	// ==========================================================
	// grant toggling after frame assertion
	wire tog_hit = toggle_en && (tog_cnt_r == (`ARB_TOGGLE_DELAY - `ARB_TOGGLE_ONE));

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			pci_arb_pkg::ST_IDLE:
				if (pick_bus.valid)
					state_nxt = pci_arb_pkg::ST_WAIT;
			pci_arb_pkg::ST_WAIT:
				if (release_gnt)
					state_nxt = pci_arb_pkg::ST_IDLE;
				else if (frame_fall)
					state_nxt = pci_arb_pkg::ST_XFER;
			pci_arb_pkg::ST_XFER:
				if (release_gnt)
					state_nxt = pci_arb_pkg::ST_IDLE;
			default:
				state_nxt = pci_arb_pkg::ST_IDLE;
		endcase
	end

	pci_arb_pkg::req_idx_t owner_nxt;
	assign owner_nxt = new_grant ? pick_bus.winner : owner_r;
	wire [3:0] grant_nxt = (state_nxt != pci_arb_pkg::ST_IDLE && !tog_hit) ?
		(4'h1 << owner_nxt) : 4'h0;

	// refresh once all other enabled masters have had a turn
	wire refresh_now = refresh_en && (|broken_r) && (&(served_r | broken_r | ~enables));
	wire [3:0] broken_set = bm_timeout ? owner_hot : 4'h0;
	wire [3:0] broken_nxt = (refresh_now ? 4'h0 : broken_r) | broken_set;
	wire [3:0] served_base = (refresh_now || bm_timeout) ? 4'h0 : served_r;
	wire [3:0] served_nxt = served_base | (new_grant ? (4'h1 << pick_bus.winner) : 4'h0);

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			state_r <= pci_arb_pkg::ST_IDLE;
			owner_r <= 2'h0;
			broken_r <= 4'h0;
			served_r <= 4'h0;
		end
		else
		begin
			state_r <= state_nxt;
			owner_r <= owner_nxt;
			broken_r <= broken_nxt;
			served_r <= served_nxt;
		end
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			bm_cnt_r <= 5'h00;
			fair_cnt_r <= 8'h00;
			armed_r <= 1'b0;
			tog_cnt_r <= 2'h0;
		end
		else
		begin
			if (new_grant)
				bm_cnt_r <= 5'h00;
			else if (bm_count)
				bm_cnt_r <= bm_cnt_r + `ARB_BM_ONE;
			if (new_grant)
				fair_cnt_r <= fair_init;
			else if (fair_dec)
				fair_cnt_r <= fair_cnt_r - `ARB_FAIR_ONE;
			if (new_grant || !granted)
				armed_r <= 1'b0;
			else if (frame_fall)
				armed_r <= 1'b1;
			if (!granted || new_grant)
				tog_cnt_r <= 2'h0;
			else if (frame_fall)
				tog_cnt_r <= `ARB_TOGGLE_ONE;
			else if (tog_cnt_r != 2'h0 && tog_cnt_r != `ARB_TOGGLE_DELAY)
				tog_cnt_r <= tog_cnt_r + `ARB_TOGGLE_ONE;
		end
	end

	// ==========================================================
	// pin outputs; external mode forwards the bridge request outward
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			pci_gnt_l <= 3'h7;
			bridge_gnt <= 1'b0;
			ext_arb_req_l <= 1'b1;
		end
		else
		begin
			pci_gnt_l <= ~grant_nxt[3:1];
			bridge_gnt <= ext_mode ? ext_gnt_s : grant_nxt[0];
			ext_arb_req_l <= ~(ext_mode && bridge_req);
		end
	end

	assign broken_mask = broken_r;

endmodule : pci_internal_bus_arbiter

`default_nettype wire

// file: design/pci_arb_defs.svh
// constants of the internal pci bus arbiter
`ifndef PCI_ARB_DEFS_SVH
`define PCI_ARB_DEFS_SVH

// ==========================================================
// register map
`define ARB_REG_OFFSET 8'h48
`define ARB_REG_RESET 32'h0000801f
`define ARB_REG_WMASK 32'h001ffe1f

// ==========================================================
// field positions
`define ARB_EN_LSB 0
`define ARB_EN_MSB 3
`define ARB_EXT_BIT 9
`define ARB_BM_EN_BIT 10
`define ARB_REFRESH_BIT 11
`define ARB_FAIR_LSB 12
`define ARB_FAIR_MSB 19
`define ARB_TOGGLE_BIT 20

// ==========================================================
// timing and sizes
`define ARB_NUM_REQ 4
`define ARB_BM_CYCLES 5'h10
`define ARB_BM_ONE 5'h01
`define ARB_TOGGLE_DELAY 2'h2
`define ARB_TOGGLE_ONE 2'h1
`define ARB_FAIR_ZERO 8'h00
`define ARB_FAIR_ONE 8'h01

`endif

// file: design/pci_arb_pkg.sv
// types shared by the pci bus arbiter modules
package pci_arb_pkg;

	// ==========================================================
	// arbiter states, gray along idle -> wait -> transfer
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_XFER = 2'b11
	} arb_state_t;

	typedef logic [1:0] req_idx_t;

endpackage : pci_arb_pkg

// file: design/arb_pick_if.sv
// interface between the arbiter core and its rotating picker
`timescale 1ns/100ps
`default_nettype none

interface arb_pick_if;
	logic [3:0] eligible;
	pci_arb_pkg::req_idx_t last;
	logic valid;
	pci_arb_pkg::req_idx_t winner;

	modport picker
	(
		input eligible,
		input last,
		output valid,
		output winner
	);

	modport user
	(
		output eligible,
		output last,
		input valid,
		input winner
	);
endinterface : arb_pick_if

`default_nettype wire

// file: design/arb_rr_pick.sv
// rotating priority picker: first eligible requester after the last one served
`timescale 1ns/100ps
`default_nettype none

module arb_rr_pick
(
	arb_pick_if.picker pk
);

	// ==========================================================
	// rotate the request mask so the slot after the last winner comes first
	wire [7:0] dbl_mask = {pk.eligible, pk.eligible};
	wire [2:0] base = {1'b0, pk.last} + 3'h1;
	wire [3:0] rot = dbl_mask[base +: 4];
	logic [1:0] pos;

	always_comb
	begin
		casez (rot)
			4'b???1: pos = 2'h0;
			4'b??10: pos = 2'h1;
			4'b?100: pos = 2'h2;
			4'b1000: pos = 2'h3;
			default: pos = 2'h0;
		endcase
	end

	wire [2:0] win_sum = base + {1'b0, pos};

	assign pk.valid = |pk.eligible;
	assign pk.winner = win_sum[1:0];

endmodule : arb_rr_pick

`default_nettype wire

// file: tb/pci_master_model.sv
// behavioural model of the three external pci masters
`timescale 1ns/100ps
`default_nettype none
module pci_master_model
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [2:0] gnt_l,
	input wire logic [2:0] want,
	input wire logic [2:0] prompt,
	output logic [2:0] req_l,
	output logic frame_l,
	output logic irdy_l
);
	// ====
	// bus lines are pulled up, so a released frame reads high
	always_ff @(posedge sys_clk or posedge reset)
		if (reset)
		begin
			req_l <= 3'h7;
			frame_l <= 1'b1;
			irdy_l <= 1'b1;
		end
		else
		begin
			req_l <= ~want;
			frame_l <= ~|(~gnt_l & want & prompt);
			irdy_l <= ~|(~gnt_l & want & prompt);
		end
endmodule : pci_master_model
`default_nettype wire

// file: tb/pci_internal_bus_arbiter_props.sv
// port assertions of the pci bus arbiter
`timescale 1ns/100ps
`default_nettype none
module arb_props
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic cfg_rd,
	input wire logic cfg_rvalid,
	input wire logic bridge_req,
	input wire logic bridge_gnt,
	input wire logic [2:0] pci_req_l,
	input wire logic [2:0] pci_gnt_l,
	input wire logic pci_frame_l,
	input wire logic ext_arb_req_l,
	input wire logic [3:0] broken_mask
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic [5:0] idle_r;
	// ====
	// idle cycles master 2 held grant; held, not cleared, when grant drops
	always_ff @(posedge sys_clk or posedge reset)
		if (reset)
			idle_r <= 6'h00;
		else
			idle_r <= !pci_frame_l ? 6'h00 : idle_r + {5'h00, !pci_gnt_l[1]};
	sequence ext_held;
		!ext_arb_req_l ##1 !ext_arb_req_l;
	endsequence
	one_grant_a: assert property ($onehot0({~pci_gnt_l, bridge_gnt}))
		else $error("two grants");
	rd_answer_a: assert property (cfg_rd |=> cfg_rvalid)
		else $error("read unanswered");
	bgnt_cause_a: assert property ($rose(bridge_gnt) |-> $past(bridge_req))
		else $error("bridge grant without request");
	bgnt_drop_a: assert property (bridge_gnt && !bridge_req |-> ##[1:2] !bridge_gnt)
		else $error("bridge grant kept");
	m1_cause_a: assert property ($fell(pci_gnt_l[0]) |-> !$past(pci_req_l[0], 3))
		else $error("master 1 grant without request");
	ext_excl_a: assert property (ext_held |-> &pci_gnt_l)
		else $error("internal grant in external mode");
	ext_req_a: assert property ($fell(ext_arb_req_l) |-> $past(bridge_req))
		else $error("external request without cause");
	bm_count_a: assert property ($rose(broken_mask[2]) |-> idle_r >= 6'h0f)
		else $error("broken too early");
endmodule : arb_props
bind pci_internal_bus_arbiter arb_props u_props (.sys_clk, .reset, .cfg_rd, .cfg_rvalid,
	.bridge_req, .bridge_gnt, .pci_req_l, .pci_gnt_l, .pci_frame_l, .ext_arb_req_l,
	.broken_mask);
`default_nettype wire

// file: tb/pci_internal_bus_arbiter_bench.sv
// self-checking bench of the pci bus arbiter
`timescale 1ns/100ps
`default_nettype none
`include "pci_arb_defs.svh"
module pci_internal_bus_arbiter_bench;
	logic sys_clk = 1'b0, reset = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, bridge_req = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [3:0] cfg_be = 4'h0, broken_mask;
	logic [31:0] cfg_wdata = 32'h0, cfg_rdata, exp_q[$];
	logic [2:0] pci_req_l, pci_gnt_l, want = 3'h0, prompt = 3'h7;
	logic cfg_rvalid, bridge_gnt, pci_frame_l, pci_irdy_l, ext_arb_req_l;
	logic ext_arb_gnt_l = 1'b1;
	integer seed = 32'hd379c403;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	pci_internal_bus_arbiter dut (.sys_clk, .reset, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be,
		.cfg_wdata, .cfg_rdata, .cfg_rvalid, .bridge_req, .bridge_gnt, .pci_req_l,
		.pci_gnt_l, .pci_frame_l, .pci_irdy_l, .ext_arb_req_l, .ext_arb_gnt_l, .broken_mask);
	pci_master_model pm (.sys_clk, .reset, .gnt_l(pci_gnt_l), .want, .prompt,
		.req_l(pci_req_l), .frame_l(pci_frame_l), .irdy_l(pci_irdy_l));
	initial
		forever #4 sys_clk = ~sys_clk;
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	// grant vector: bit 0 bridge, bits 3:1 masters 1 to 3
	task automatic await(input logic [3:0] e, input int n);
		while ({~pci_gnt_l, bridge_gnt} !== e && n > 0)
		begin
			@(negedge sys_clk);
			n--;
		end
		chk("grant", {28'h0, e}, {28'h0, ~pci_gnt_l, bridge_gnt});
	endtask : await
	task automatic cw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge sys_clk);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		cfg_be <= be;
		@(posedge sys_clk);
		cfg_wr <= 1'b0;
	endtask : cw
	task automatic cr(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge sys_clk);
		cfg_rd <= 1'b1;
		cfg_addr <= a;
		@(posedge sys_clk);
		cfg_rd <= 1'b0;
	endtask : cr
	always @(posedge sys_clk)
		if (cfg_rvalid === 1'b1)
			chk("rdata", exp_q.pop_front(), cfg_rdata);
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			wrap_up();
		end
	end
	initial
	begin
		logic [31:0] rd;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		cw(8'h44, 32'hffffffff, 4'hf);
		cr(8'h48, `ARB_REG_RESET);
		cr(8'h44, 32'h0);
		rd = $random(seed);
		cw(8'h48, rd, 4'hf);
		cr(8'h48, rd & `ARB_REG_WMASK);
		cw(8'h48, 32'h0, 4'h1);
		cr(8'h48, rd & `ARB_REG_WMASK & 32'hffffff00);
		cw(8'h48, `ARB_REG_RESET, 4'hf);
		bridge_req <= 1'b1;
		await(4'h1, 4);
		cw(8'h48, 32'h0000801e, 4'h1);
		await(4'h0, 4);
		want <= 3'b001;
		await(4'h2, 8);
		cw(8'h48, 32'h0, 4'h6);
		want <= 3'b101;
		repeat (40) @(negedge sys_clk);
		await(4'h2, 0);
		cw(8'h48, 32'h0000801e, 4'h6);
		await(4'h8, 30);
		want <= 3'b000;
		await(4'h0, 8);
		cw(8'h48, 32'h0000801a, 4'h1);
		want <= 3'b010;
		repeat (10) @(negedge sys_clk);
		await(4'h0, 0);
		cw(8'h48, 32'h0000801e, 4'h1);
		await(4'h4, 8);
		want <= 3'b000;
		cw(8'h48, 32'h0010801e, 4'h4);
		want <= 3'b001;
		await(4'h2, 8);
		await(4'h0, 8);
		await(4'h2, 2);
		want <= 3'b000;
		cw(8'h48, 32'h0000021e, 4'h6);
		want <= 3'b001;
		repeat (6) @(negedge sys_clk);
		chk("ext req", 32'h0, {31'h0, ext_arb_req_l});
		await(4'h0, 0);
		@(posedge sys_clk);
		ext_arb_gnt_l <= 1'b0;
		await(4'h1, 6);
		@(posedge sys_clk);
		ext_arb_gnt_l <= 1'b1;
		await(4'h0, 6);
		want <= 3'b000;
		bridge_req <= 1'b0;
		@(posedge sys_clk);
		reset <= 1'b1;
		@(posedge sys_clk);
		reset <= 1'b0;
		cw(8'h48, 32'h0000841f, 4'h2);
		prompt <= 3'b101;
		want <= 3'b010;
		await(4'h4, 8);
		await(4'h0, 24);
		chk("broken", 32'h4, {28'h0, broken_mask});
		want <= 3'b000;
		repeat (3) @(posedge sys_clk);
		want <= 3'b010;
		repeat (12) @(negedge sys_clk);
		await(4'h0, 0);
		// refresh on: masters 1 and 3 get a turn, then master 2 is back in the pool
		cw(8'h48, 32'h00008c1e, 4'h3);
		want <= 3'b111;
		await(4'h4, 80);
		wrap_up();
	end
endmodule : pci_internal_bus_arbiter_bench
`default_nettype wire
